/* verilog/rtco_serial_port.v */
// One-bit serial host port with user byte space, command decode and notification FIFO
`timescale 1ns/1ps
`include "rtco_serial_map.vh"
// Functional notes
// (RL1) A cycle always opens with four address writes, one bit each.
// (RL2) Reads while waiting for the first address bit never start a cycle.
// (RL3) Address bits arrive least significant first, first write is bit zero.
// (RL4) The address picks one eight-bit byte of the user space.
// (RL5) Eight reads return the addressed byte from bit zero, cycle ends after bit seven.
// (RL6) Eight writes load the byte from bit zero, cycle ends on bit seven.
// (RL7) A command cycle has only the four address bits, no data phase.
// (RL8) The address is decoded as soon as the fourth bit is written.
// (RL9) Codes E and F end the cycle at once and run their command.
// (RL10) After a command the next write is the first address bit again.
// (RL11) The host decodes its address bus to make the active-low select.
// (RL12) Separate style: select plus read pulse or write pulse frames each bit.
// (RL13) Strobe style: strobe with direction and select, or strobe tied to select.
// (RL14) All bits travel on one two-way line, any line of the data bus.
// (RL15) A three-wire link with clock, data line and strobe carries the same protocol; the code also takes direction from writeN.
// (RL16) Timekeeping counters are hidden; only the user byte space is accessible.
// (RL17) Locations 0-1 status, 2-5 time, 6-9 date.
// (RL18) Code E loads counters from 2-9 and clears 1, unless lock bit 4 of 0 set.
// (RL19) Code F copies counters into 2-9; hosts do this before reading time.
// (RL20) After host reset the host does eight reads to resync the port.
// (RL21) A bit counter tracks phases, back to address start after bit seven or command.

module rtco_fifo #(
  parameter W  = `RTCO_FIFO_W,
  parameter D  = `RTCO_FIFO_D,
  parameter AW = `RTCO_FIFO_AW
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         nrst,
  // Fill side
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  // Drain side
  output wire         outValid,
  input  wire         outReady,
  output wire [W-1:0] outData
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wrPtr;
  reg  [AW-1:0] rdPtr;
  reg  [AW:0]   fill;
  wire          doPush;
  wire          doPop;

  // Full and empty come straight from the fill count
  assign inReady  = (fill != D[AW:0]);
  assign outValid = (fill != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  // Storage is written without reset; only pointers and the fill count need a defined value
  always @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointer and count bookkeeping
  always @(posedge mclk) begin
    if (!nrst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      fill  <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (doPush & !doPop) begin
        fill <= fill + 1'b1;
      end else if (doPop & !doPush) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule

module rtco_serial_port (
  // Clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // Style straps
  input  wire        strobeStyle,
  input  wire        serialMode,
  // Parallel bus pins
  input  wire        chipSelN,
  input  wire        readN,
  input  wire        writeN,
  // Three-wire link pins
  input  wire        serClk,
  input  wire        serStrobe,
  // Shared data line
  input  wire        ioIn,
  output reg         ioOut,
  output reg         ioOe,
  // Seconds tick from the crystal side
  input  wire        secTick,
  // Write notifications to user logic
  output wire        noteValid,
  input  wire        noteReady,
  output wire [11:0] noteData,
  // Command strobes for user logic
  output reg         loadDone,
  output reg         snapDone
);
  localparam ST_ADDR = `RTCO_ST_ADDR;
  localparam ST_DATA = `RTCO_ST_DATA;
  localparam ST_HOLD = `RTCO_ST_HOLD;

  // Two-stage synchronisers for every pin except the two style straps
  reg  [6:0] syncA;
  reg  [6:0] syncB;
  reg        accLive;
  reg        actPrev;
  reg        tickPrev;

  reg  [1:0] state;
  reg  [`RTCO_CNT_W-1:0] bitCnt;
  reg  [3:0] addr;
  reg  [7:0] shift;
  reg        accRead;
  reg        pushPend;
  reg  [7:0] ram  [0:`RTCO_LOC_COUNT-1];
  reg  [7:0] bank [0:`RTCO_BANK_COUNT-1];

  wire       fifoReady;

  // True for a location inside the user data space
  function locValid;
    input [3:0] a;
    begin
      locValid = (a <= `RTCO_LOC_LAST);
    end
  endfunction

  // Pins are asynchronous to mclk, so nothing reads them before two flops
  // Reset to the pins' idle levels; anything else fakes an edge at release
  always @(posedge mclk) begin
    if (!nrst) begin
      syncA <= `RTCO_SYNC_IDLE;
      syncB <= `RTCO_SYNC_IDLE;
    end else begin
      syncA <= {secTick, serStrobe, serClk, ioIn, writeN, readN, chipSelN};
      syncB <= syncA;
    end
  end

  // Synchronised pins, select and read turned active high
  wire       sCs   = !syncB[0];
  wire       sRd   = !syncB[1];
  wire       sWrN  = syncB[2];
  wire       sIo   = syncB[3];
  wire       sSck  = syncB[4];
  wire       sStb  = syncB[5];
  wire       sTick = syncB[6];

  // (RL12) separate pulses
  // (RL13) strobe with direction; a strobe tied to select behaves the same
  wire       busAct  = strobeStyle ? (sCs & sRd) : (sCs & (sRd | !sWrN));
  wire       busRead = strobeStyle ? sWrN : sRd;
  // (RL15) link of clock, strobe and data line, with writeN as a fourth wire for direction
  wire       act     = serialMode ? (sStb & sSck) : busAct;
  wire       dirRead = serialMode ? sWrN : busRead;

  // Edge history of the access window and the tick
  always @(posedge mclk) begin
    if (!nrst) begin
      actPrev  <= 1'b0;
      tickPrev <= 1'b0;
    end else begin
      actPrev  <= act;
      tickPrev <= sTick;
    end
  end

  // Accesses are ignored while a byte notification waits for FIFO room
  wire       accStart  = act & !actPrev & (state != ST_HOLD);
  wire       accEnd    = !act & actPrev & accLive;
  wire       tickPulse = sTick & !tickPrev;

  // (RL3) LSB first shifting of address and data
  wire [3:0] next_addr  = {sIo, addr[3:1]};
  wire [7:0] next_shift = {sIo, shift[7:1]};

  // (RL8) decode on the fourth address bit
  wire       lockSet  = ram[`RTCO_LOC_STAT0][`RTCO_LOCK_BIT];
  wire       addrDone = accEnd & !accRead & (state == ST_ADDR) & (bitCnt == `RTCO_CNT_ADDR_LAST);
  wire       doSnap   = addrDone & (next_addr == `RTCO_CMD_SNAP);
  // (RL18) load is blocked by the lock bit
  wire       doLoad   = addrDone & (next_addr == `RTCO_CMD_LOAD) & !lockSet;
  wire       byteDone = accEnd & !accRead & (state == ST_DATA) & (bitCnt == `RTCO_CNT_DATA_LAST);

  // Latch direction at the start of each access; a window opened in the stall never closes live
  always @(posedge mclk) begin
    if (!nrst) begin
      accRead <= 1'b0;
      accLive <= 1'b0;
    end else begin
      accLive <= accStart | (accLive & act);
      if (accStart) begin
        accRead <= dirRead;
      end
    end
  end

  // Phase sequencer
  always @(posedge mclk) begin
    if (!nrst) begin
      state    <= ST_ADDR;
      bitCnt   <= {`RTCO_CNT_W{1'b0}};
      addr     <= 4'h0;
      shift    <= `RTCO_BYTE_ZERO;
      pushPend <= 1'b0;
    end else begin
      case (state)
        ST_ADDR: begin
          // (RL1) only writes advance the address phase
          // (RL2) reads here are ignored
          if (accEnd & !accRead) begin
            addr <= next_addr;
            if (bitCnt == `RTCO_CNT_ADDR_LAST) begin
              // (RL9) command codes end the cycle
              // (RL7) no data phase after a command
              if (next_addr == `RTCO_CMD_LOAD || next_addr == `RTCO_CMD_SNAP) begin
                // (RL10) next write is address bit zero
                bitCnt <= {`RTCO_CNT_W{1'b0}};
              end else begin
                bitCnt <= bitCnt + 1'b1;
                state  <= ST_DATA;
              end
            end else begin
              bitCnt <= bitCnt + 1'b1;
            end
          end
        end
        ST_DATA: begin
          if (accEnd) begin
            if (!accRead) begin
              shift <= next_shift;
            end
            // (RL21) back to the address phase after the eighth bit
            if (bitCnt == `RTCO_CNT_DATA_LAST) begin
              bitCnt <= {`RTCO_CNT_W{1'b0}};
              if (!accRead && locValid(addr)) begin
                state    <= ST_HOLD;
                pushPend <= 1'b1;
              end else begin
                state <= ST_ADDR;
              end
            end else begin
              bitCnt <= bitCnt + 1'b1;
            end
          end
        end
        ST_HOLD: begin
          // Stall until the notification FIFO takes the byte
          if (fifoReady) begin
            pushPend <= 1'b0;
            state    <= ST_ADDR;
          end
        end
        default: begin
          state  <= ST_ADDR;
          bitCnt <= {`RTCO_CNT_W{1'b0}};
        end
      endcase
    end
  end

  // (RL5) read data bit from flops, driven only during a data-phase read
  // (RL14) single two-way line
  always @(posedge mclk) begin
    if (!nrst) begin
      ioOut <= 1'b0;
      ioOe  <= 1'b0;
    end else if (accStart) begin
      ioOut <= (locValid(addr) && state == ST_DATA) ? ram[addr][bitCnt - `RTCO_ADDR_BITS] : 1'b0;
      ioOe  <= dirRead & (state == ST_DATA);
    end else if (accEnd) begin
      ioOe <= 1'b0;
    end
  end

  // User byte space and hidden counter bank
  // (RL16) the bank has no path to the host except through commands
  // (RL17) status 0-1, time 2-5, date 6-9
  genvar i;
  generate
    for (i = 0; i < `RTCO_LOC_COUNT; i = i + 1) begin : gLoc
      always @(posedge mclk) begin
        if (!nrst) begin
          ram[i] <= `RTCO_BYTE_ZERO;
        end else if (byteDone && addr == i) begin
          // (RL6) commit the whole byte on bit seven
          // (RL4) address selects the byte
          ram[i] <= next_shift;
        end else if (i == `RTCO_LOC_STAT1 && doLoad) begin
          // (RL18) load clears the change flags
          ram[i] <= `RTCO_BYTE_ZERO;
        end else if (i == `RTCO_LOC_STAT1 && doSnap) begin
          // (RL19) change flags of each copied location
          ram[i] <= {bank[7] != ram[9], bank[6] != ram[8], bank[5] != ram[7],
                     bank[4] != ram[6], bank[3] != ram[5], bank[2] != ram[4],
                     bank[1] != ram[3], bank[0] != ram[2]};
        end else if (i >= `RTCO_LOC_TIME && doSnap) begin
          // (RL19) copy counters into the byte space
          ram[i] <= bank[i - `RTCO_LOC_TIME];
        end
      end
    end
    for (i = 0; i < `RTCO_BANK_COUNT; i = i + 1) begin : gBank
      always @(posedge mclk) begin
        if (!nrst) begin
          bank[i] <= `RTCO_BYTE_ZERO;
        end else if (doLoad) begin
          // (RL18) overwrite running counters
          bank[i] <= ram[i + `RTCO_LOC_TIME];
        end else if (i == 0 && tickPulse) begin
          // Only seconds count here; the calendar lives elsewhere
          if (bank[i] >= `RTCO_SEC_MAX) begin
            bank[i] <= `RTCO_BYTE_ZERO;
          end else if (bank[i][3:0] >= `RTCO_BCD_UNIT_MAX) begin
            bank[i] <= {bank[i][7:4] + 1'b1, 4'h0};
          end else begin
            bank[i] <= bank[i] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // One-cycle command strobes for user logic
  always @(posedge mclk) begin
    if (!nrst) begin
      loadDone <= 1'b0;
      snapDone <= 1'b0;
    end else begin
      loadDone <= doLoad;
      snapDone <= doSnap;
    end
  end

  // Each byte written to locations 0-9 is announced as {address, data}
  rtco_fifo #(
    .W  (`RTCO_FIFO_W),
    .D  (`RTCO_FIFO_D),
    .AW (`RTCO_FIFO_AW)
  ) uNotes (
    .mclk     (mclk),
    .nrst     (nrst),
    .inValid  (pushPend),
    .inReady  (fifoReady),
    .inData   ({addr, ram[addr]}),
    .outValid (noteValid),
    .outReady (noteReady),
    .outData  (noteData)
  );
endmodule

/* verilog/rtco_serial_map.vh */
// Constant map for the one-bit serial host port of the real-time clock
`ifndef RTCO_SERIAL_MAP_VH
`define RTCO_SERIAL_MAP_VH

// Frame layout
`define RTCO_ADDR_BITS      4
`define RTCO_DATA_BITS      8
`define RTCO_CNT_W          4
`define RTCO_CNT_ADDR_LAST  4'h3
`define RTCO_CNT_DATA_LAST  4'hB

// Command codes in the address command space
`define RTCO_CMD_LOAD       4'hE
`define RTCO_CMD_SNAP       4'hF

// Data space locations
`define RTCO_LOC_STAT0      4'h0
`define RTCO_LOC_STAT1      4'h1
`define RTCO_LOC_TIME       4'h2
`define RTCO_LOC_LAST       4'h9
`define RTCO_LOC_COUNT      10
`define RTCO_BANK_COUNT     8
`define RTCO_LOCK_BIT       4

// Reset values and seconds counting (BCD)
`define RTCO_BYTE_ZERO      8'h00
`define RTCO_SYNC_IDLE      7'h07   // Pins at rest: select and strobes high, rest low
`define RTCO_SEC_MAX        8'h59
`define RTCO_BCD_UNIT_MAX   4'h9

// Write-notification FIFO
`define RTCO_FIFO_W         12
`define RTCO_FIFO_D         16
`define RTCO_FIFO_AW        4

// Sequencer states
`define RTCO_ST_ADDR        2'h0
`define RTCO_ST_DATA        2'h1
`define RTCO_ST_HOLD        2'h2

`endif

/* testbench/rtco_serial_port_monitor.sv */
// Concurrent checks on the pins of the serial host port
`timescale 1ns/1ps
module rtco_serial_port_monitor (
  // Clock and reset
  input wire        mclk,
  input wire        nrst,
  // Straps and strobes
  input wire        strobeStyle,
  input wire        serialMode,
  input wire        chipSelN,
  input wire        readN,
  input wire        writeN,
  input wire        serClk,
  input wire        serStrobe,
  // Data line and user side
  input wire        ioOut,
  input wire        ioOe,
  input wire        noteValid,
  input wire        noteReady,
  input wire [11:0] noteData,
  input wire        loadDone,
  input wire        snapDone
);
  // Access window as the pins frame it, before synchronising
  wire pinAct = serialMode ? (serStrobe & serClk) :
                strobeStyle ? (!chipSelN & !readN) : (!chipSelN & (!readN | !writeN));

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence winClose;
    pinAct ##1 !pinAct;
  endsequence

  a_load_one_pulse: assert property (loadDone |=> !loadDone)
    else $error("load strobe longer than one cycle");
  a_snap_one_pulse: assert property (snapDone |=> !snapDone)
    else $error("snapshot strobe longer than one cycle");
  a_cmd_exclusive: assert property (!(loadDone && snapDone))
    else $error("both commands at once");
  a_cmd_no_data: assert property ((loadDone || snapDone) |-> !ioOe)
    else $error("line driven after a command");
  a_oe_rise_late: assert property ($rose(ioOe) |-> $past(pinAct, 3))
    else $error("line driven outside a window");
  a_oe_drop_close: assert property (winClose |-> ##[1:4] !ioOe)
    else $error("line still driven after window");
  a_out_stands: assert property (ioOe && $past(ioOe) |-> $stable(ioOut))
    else $error("read bit changed in window");
  a_note_held: assert property (noteValid && !noteReady |=> noteValid && $stable(noteData))
    else $error("notification dropped while stalled");
endmodule

bind rtco_serial_port rtco_serial_port_monitor chk (
  .mclk(mclk), .nrst(nrst), .strobeStyle(strobeStyle), .serialMode(serialMode),
  .chipSelN(chipSelN), .readN(readN), .writeN(writeN), .serClk(serClk),
  .serStrobe(serStrobe), .ioOut(ioOut), .ioOe(ioOe), .noteValid(noteValid),
  .noteReady(noteReady), .noteData(noteData), .loadDone(loadDone), .snapDone(snapDone)
);

/* testbench/rtco_host_model.sv */
// Behavioural bus host that drives the serial port pins
`timescale 1ns/1ps
module rtco_host_model (
  // Clock
  input  wire  mclk,
  // Style straps
  output wire  strobeStyle,
  output wire  serialMode,
  // Bus and link pins
  output logic chipSelN,
  output logic readN,
  output logic writeN,
  output logic serClk,
  output logic serStrobe,
  // Data line
  output logic ioIn,
  input  wire  ioOut,
  input  wire  ioOe
);
  logic [1:0] mode;

  assign strobeStyle = (mode == 2'h1);
  assign serialMode  = (mode == 2'h2);

  // Idle pins; the link clock stands still outside frames
  initial begin
    mode      = 2'h0;
    chipSelN  = 1'b1;
    readN     = 1'b1;
    writeN    = 1'b1;
    serClk    = 1'b0;
    serStrobe = 1'b0;
    ioIn      = 1'b0;
  end

  // One single-bit access; window held well past the three-edge answer
  task acc(input logic wr, input logic d, output logic q, output logic oe);
    @(posedge mclk);
    ioIn      <= d;
    // select and direction ahead of strobe
    chipSelN  <= (mode == 2'h2);
    serStrobe <= (mode == 2'h2);
    if (mode != 2'h0) writeN <= !wr;
    @(posedge mclk);
    if (mode == 2'h2) serClk <= 1'b1;
    else if (mode == 2'h1 || !wr) readN <= 1'b0;
    else writeN <= 1'b0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    q  = ioOut;
    oe = ioOe;
    @(posedge mclk);
    readN  <= 1'b1;
    serClk <= 1'b0;
    if (mode == 2'h0) writeN <= 1'b1;
    repeat (3) @(posedge mclk);
    chipSelN  <= 1'b1;
    serStrobe <= 1'b0;
    writeN    <= 1'b1;
    // released line shows the inverse, never a stale bit
    ioIn      <= !d;
    repeat (3) @(posedge mclk);
  endtask

  // four address writes, lowest bit first
  task sendAddr(input logic [3:0] a);
    logic q, oe;
    for (int i = 0; i < 4; i++) acc(1'b1, a[i], q, oe);
  endtask

  task writeByte(input logic [3:0] a, input logic [7:0] d);
    logic q, oe;
    sendAddr(a);
    for (int i = 0; i < 8; i++) acc(1'b1, d[i], q, oe);
  endtask

  task readByte(input logic [3:0] a, output logic [7:0] d, output logic oeAll);
    logic q, oe;
    sendAddr(a);
    oeAll = 1'b1;
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, 1'b0, q, oe);
      d[i]  = q;
      oeAll = oeAll & oe;
    end
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the one-bit serial host port
`timescale 1ns/1ps
`include "rtco_serial_map.vh"
module tb;
  logic        mclk, nrst, secTick, noteReady;
  wire         strobeStyle, serialMode, chipSelN, readN, writeN, serClk, serStrobe;
  wire         ioIn, ioOut, ioOe, noteValid, loadDone, snapDone;
  wire  [11:0] noteData;
  integer      failures, checks, loadSeen, snapSeen;
  logic [7:0]  b;
  logic        oe, q;

  initial begin
    mclk      = 1'b0;
    nrst      = 1'b0;
    secTick   = 1'b0;
    noteReady = 1'b1;
    failures  = 0;
    checks    = 0;
    loadSeen  = 0;
    snapSeen  = 0;
  end

  always #2 mclk = ~mclk;

  // Command strobes are one cycle, so count them as they pass
  always @(posedge mclk) begin
    if (loadDone === 1'b1) loadSeen <= loadSeen + 1;
    if (snapDone === 1'b1) snapSeen <= snapSeen + 1;
  end

  rtco_serial_port dut (
    .mclk(mclk), .nrst(nrst), .strobeStyle(strobeStyle), .serialMode(serialMode),
    .chipSelN(chipSelN), .readN(readN), .writeN(writeN), .serClk(serClk),
    .serStrobe(serStrobe), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .secTick(secTick),
    .noteValid(noteValid), .noteReady(noteReady), .noteData(noteData),
    .loadDone(loadDone), .snapDone(snapDone));

  rtco_host_model host (
    .mclk(mclk), .strobeStyle(strobeStyle), .serialMode(serialMode),
    .chipSelN(chipSelN), .readN(readN), .writeN(writeN), .serClk(serClk),
    .serStrobe(serStrobe), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

  task check(input logic [11:0] seen, input logic [11:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Reads while waiting for the address never drive the line
  task t_resync;
    for (int i = 0; i < 8; i++) begin
      host.acc(1'b0, 1'b0, q, oe);
      check(12'(oe), 12'h0);
    end
  endtask

  task t_snapshot;
    integer s0;
    secTick <= 1'b1;
    repeat (4) @(posedge mclk);
    secTick <= 1'b0;
    repeat (4) @(posedge mclk);
    s0 = snapSeen;
    host.sendAddr(`RTCO_CMD_SNAP);
    repeat (4) @(posedge mclk);
    check(12'(snapSeen - s0), 12'h1);
    host.readByte(4'h2, b, oe);
    check(12'(b), 12'h001);
    check(12'(oe), 12'h1);
    host.readByte(4'h1, b, oe);
    check(12'(b), 12'h001);
  endtask

  // Every timing style, byte written then read back
  task t_modes;
    for (int m = 0; m < 3; m++) begin
      host.mode <= 2'(m);
      repeat (4) @(posedge mclk);
      host.writeByte(4'(4 + m), 8'hA5 ^ 8'(m));
      host.readByte(4'(4 + m), b, oe);
      check(12'(b), 12'(8'hA5 ^ 8'(m)));
    end
    host.mode <= 2'h0;
    repeat (4) @(posedge mclk);
  endtask

  task t_lock_load;
    integer l0;
    host.writeByte(4'h0, 8'h10);
    l0 = loadSeen;
    host.sendAddr(`RTCO_CMD_LOAD);
    repeat (6) @(posedge mclk);
    check(12'(loadSeen - l0), 12'h0);
    host.writeByte(4'h0, 8'h00);
    host.writeByte(4'h2, 8'h42);
    l0 = loadSeen;
    host.sendAddr(`RTCO_CMD_LOAD);
    repeat (6) @(posedge mclk);
    check(12'(loadSeen - l0), 12'h1);
    host.readByte(4'h1, b, oe);
    check(12'(b), 12'h000);
    host.sendAddr(`RTCO_CMD_SNAP);
    host.readByte(4'h2, b, oe);
    check(12'(b), 12'h042);
  endtask

  // Stall the user side past the buffer depth, then drain it
  task t_fifo;
    integer n;
    noteReady <= 1'b0;
    for (int i = 0; i < 17; i++) host.writeByte(4'h7, 8'h20 + 8'(i));
    noteReady <= 1'b1;
    n = 0;
    for (int k = 0; k < 80; k++) begin
      @(negedge mclk);
      if (noteValid === 1'b1) begin
        check(noteData, {4'h7, 8'h20 + 8'(n)});
        n = n + 1;
      end
    end
    check(12'(n), 12'd17);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_resync;
    t_snapshot;
    t_modes;
    t_lock_load;
    t_fifo;
    report_and_stop;
  end
endmodule
